// >>> bench/bsr_host_model.sv
`timescale 1ns/100ps
module bsr_host_model
	import bsr_pkg::*;
(
	// Clock
	input wire logic i_clock,
	// Serial pins
	input wire logic i_dout,
	output logic o_sclk,
	output logic o_din
);
	// ----------------------------------------------------------------
	// Serial bit
	// ----------------------------------------------------------------
	initial begin
		o_sclk = 1'h0;
		o_din = 1'h0;
	end
	// Returns the level left by the previous rise, so that every call
	// stays exactly one link period long
	task automatic bit_x(input logic b, output logic o);
		o_sclk <= 1'h0;
		o_din <= b;
		@(negedge i_clock);
		o = i_dout;
		repeat (4) @(posedge i_clock);
		o_sclk <= 1'h1;
		repeat (4) @(posedge i_clock);
	endtask
	task automatic idle(input int n);
		o_sclk <= 1'h0;
		repeat (n) @(posedge i_clock);
	endtask
	// ----------------------------------------------------------------
	// Frames
	// ----------------------------------------------------------------
	task automatic instr(input logic [3:0] code, output logic ack);
		logic [9:0] f;
		f = {START_PAT, code, STOP_PAT};
		for (int i = 9; i >= 0; i--) begin
			bit_x(f[i], ack);
		end
	endtask
	task automatic conv_start(input logic [3:0] code, output logic ack);
		logic o;
		instr(code, ack);
		bit_x(1'h0, o);
		bit_x(1'h0, o);
		idle(1);
	endtask
	task automatic rst_seq();
		logic o;
		for (int i = RST_LEN - 1; i >= 0; i--) begin
			bit_x(RST_PAT[i], o);
		end
		idle(1);
	endtask
	// A pause mid-word shows whether the device keeps its place
	task automatic read_word(output logic [15:0] w);
		logic o;
		w = 16'h0;
		for (int j = 1; j <= 17; j++) begin
			bit_x(1'h0, o);
			if (j > 1) w = {w[14:0], o};
			if (j == 9) idle(30);
		end
		idle(8);
	endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import bsr_pkg::*;
	logic clock = 1'h0;
	logic sys_rst = 1'h1;
	logic sclk, din, dout, conv_start, conv_temp, adc_valid, adc_ready;
	logic [15:0] adc_data;
	logic [14:0] c1 = 15'h5a3c;
	logic [11:0] c2 = 12'hb6d;
	logic [9:0] c3 = 10'h2f1;
	logic [9:0] c4 = 10'h1a7;
	logic [10:0] c5 = 11'h4d2;
	logic [5:0] c6 = 6'h2b;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	always #50 clock = ~clock;
	bsr_serial_readout #(.DEPTH(2), .CONV_CYCLES(200)) i_dut (
		.i_clock(clock), .i_sys_rst(sys_rst), .i_sclk(sclk), .i_din(din),
		.o_dout(dout), .i_coeff_one(c1), .i_coeff_two(c2),
		.i_coeff_three(c3), .i_coeff_four(c4), .i_coeff_five(c5),
		.i_coeff_six(c6), .o_conv_start(conv_start), .o_conv_temp(conv_temp),
		.i_adc_data(adc_data), .i_adc_valid(adc_valid),
		.o_adc_ready(adc_ready));
	bsr_host_model i_host (.i_clock(clock), .i_dout(dout), .o_sclk(sclk),
		.o_din(din));
	// ----------------------------------------------------------------
	// Reporting
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Well above the longest expected run of about five and a half thousand cycles
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			wrap_up();
		end
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Second pass inverts every coefficient so no bit is stuck unseen
	task automatic calib_words();
		logic [15:0] exp [4];
		logic [3:0] cmd [4];
		logic [15:0] w;
		logic ack;
		cmd = '{CMD_CALIB_WORD_ONE, CMD_CALIB_WORD_TWO, CMD_CALIB_WORD_THREE, CMD_CALIB_WORD_FOUR};
		for (int p = 0; p < 2; p++) begin
			exp = '{{c1, c5[10]}, {c5[9:0], c6}, {c4, c2[11:6]}, {c3, c2[5:0]}};
			for (int k = 0; k < 4; k++) begin
				i_host.instr(cmd[k], ack);
				check("calib ack", {15'h0, ack}, 16'h0);
				i_host.read_word(w);
				check("calib word", w, exp[k]);
				check("dout idle", {15'h0, dout}, 16'h0);
			end
			{c1, c2, c3, c4, c5, c6} <= ~{c1, c2, c3, c4, c5, c6};
			@(posedge clock);
		end
	endtask
	task automatic reset_midway();
		logic [15:0] w;
		logic ack;
		logic o;
		i_host.instr(CMD_CALIB_WORD_ONE, ack);
		repeat (5) i_host.bit_x(1'h0, o);
		i_host.rst_seq();
		i_host.instr(CMD_CALIB_WORD_FOUR, ack);
		i_host.read_word(w);
		check("word after reset", w, {c3, c2[5:0]});
		// Only the pattern can end a conversion wait this early
		i_host.conv_start(CMD_PRESSURE, ack);
		i_host.rst_seq();
		check("idle after reset", {15'h0, dout}, 16'h0);
		i_host.instr(CMD_CALIB_WORD_TWO, ack);
		i_host.read_word(w);
		check("word two after reset", w, {c5[9:0], c6});
	endtask
	task automatic fill_buffer();
		for (int k = 0; k < 2; k++) begin
			adc_valid <= 1'h1;
			adc_data <= (k == 0) ? 16'h2345 : 16'hffff;
			do @(posedge clock); while (adc_ready !== 1'h1);
		end
		adc_valid <= 1'h0;
		repeat (3) @(posedge clock);
		check("buffer full", {15'h0, adc_ready}, 16'h0);
	endtask
	task automatic convert(input logic [3:0] code, input logic temp,
		input logic feed, input logic [15:0] data, input logic [15:0] exp);
		logic ack;
		logic started;
		logic tsel;
		logic [15:0] w;
		int n;
		started = 1'h0;
		tsel = 1'h0;
		n = 0;
		i_host.rst_seq();
		// The start pulse lasts one cycle while the host is still
		// clocking, so a second process watches for it
		fork
			i_host.conv_start(code, ack);
			begin
				while (conv_start !== 1'h1 && n < 1000) begin
					@(posedge clock);
					n++;
				end
				started = conv_start;
				tsel = conv_temp;
				if (feed) begin
					adc_valid <= 1'h1;
					adc_data <= data;
					do @(posedge clock); while (adc_ready !== 1'h1);
					adc_valid <= 1'h0;
				end
			end
		join
		check("conv ack", {15'h0, ack}, 16'h1);
		n = 0;
		// Bounded wait for the end of conversion
		while (dout === 1'h1 && n < 400) begin
			@(posedge clock);
			n++;
		end
		check("conv end", {15'h0, dout}, 16'h0);
		if (dout === 1'h1) i_host.rst_seq();
		check("conv start", {15'h0, started}, 16'h1);
		check("conv kind", {15'h0, tsel}, {15'h0, temp});
		i_host.read_word(w);
		check("conv result", w, exp);
		check("dout idle", {15'h0, dout}, 16'h0);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		adc_valid = 1'h0;
		adc_data = 16'h0;
		repeat (2) @(posedge clock);
		sys_rst <= 1'h0;
		repeat (4) @(posedge clock);
		check("ready after reset", {15'h0, adc_ready}, 16'h1);
		calib_words();
		reset_midway();
		fill_buffer();
		convert(CMD_PRESSURE, 1'h0, 1'h0, 16'h0, 16'h2345);
		convert(CMD_TEMP, 1'h1, 1'h0, 16'h0, ADC_MAX);
		check("buffer drained", {15'h0, adc_ready}, 16'h1);
		convert(CMD_PRESSURE, 1'h0, 1'h1, 16'h0010, ADC_MIN);
		convert(CMD_TEMP, 1'h1, 1'h1, 16'h7abc, 16'h7abc);
		convert(CMD_TEMP, 1'h1, 1'h0, 16'h0, ADC_MIN);
		wrap_up();
	end
endmodule

// >>> common/bsr_pkg.sv
package bsr_pkg;

	// ----------------------------------------------------------------
	// Instruction framing
	// ----------------------------------------------------------------
	localparam logic [2:0] START_PAT = 3'h7;
	localparam logic [2:0] STOP_PAT = 3'h0;
	localparam logic [3:0] CMD_PRESSURE = 4'ha;
	localparam logic [3:0] CMD_TEMP = 4'h9;
	localparam logic [3:0] CMD_CALIB_WORD_ONE = 4'h5;
	localparam logic [3:0] CMD_CALIB_WORD_TWO = 4'h6;
	localparam logic [3:0] CMD_CALIB_WORD_THREE = 4'h3;
	localparam logic [3:0] CMD_CALIB_WORD_FOUR = 4'hc;
	localparam int RST_LEN = 21;
	localparam logic [20:0] RST_PAT = 21'h155540;

	// ----------------------------------------------------------------
	// Readout counts
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam logic [4:0] ACK_CLOCKS = 5'h3;
	localparam logic [4:0] RESULT_BITS = 5'h10;

	// ----------------------------------------------------------------
	// Converter range and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] ADC_MIN = 16'h1388;
	localparam logic [15:0] ADC_MAX = 16'h9088;
	localparam int CONV_TIME_MS = 35;
	localparam int CLOCK_HZ = 10000000;
	localparam int CONV_CYCLES_DEF = CONV_TIME_MS * (CLOCK_HZ / 1000);

	// ----------------------------------------------------------------
	// Coefficient widths
	// ----------------------------------------------------------------
	localparam int C1_W = 15;
	localparam int C2_W = 12;
	localparam int C3_W = 10;
	localparam int C4_W = 10;
	localparam int C5_W = 11;
	localparam int C6_W = 6;

endpackage

// >>> design/bsr_serial_readout.sv
`timescale 1ns/100ps
// Functional notes
// - Host changes input on fall; sampled rising.
// - Output bits shift on serial clock rise.
// - Output carries result, calibration or status.
// - No select; framing from serial input only.
// - Three high before, three low after code; decoding checks only the first two low.
// - Four-bit code picks conversion or word.
// - Seven instructions: two conversions, four words, reset.
// - Conversion acknowledged by rise in last stop bit.
// - Clock held low; output falls at conversion end.
// - Seventeen clocks shift out sixteen-bit result.
// - Readout pauses while clock idles, then resumes.
// - 21-bit reset pattern returns idle anywhere.
// - Word one: coefficient one, coefficient five bit ten.
// - Word two: coefficient five low, coefficient six.
// - Word three: coefficient four, coefficient two high.
// - Word four: coefficient three, coefficient two low.
// - Pressure and temperature give sixteen-bit values.
// - Conversion completes within 35 ms.
// - Results clamped to 5000 to 37000 counts.
module bsr_serial_readout
	import bsr_pkg::*;
#(
	parameter int DEPTH = 2,
	parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// Serial pins
	input wire logic i_sclk,
	input wire logic i_din,
	output logic o_dout,
	// Stored coefficients
	input wire logic [C1_W-1:0] i_coeff_one,
	input wire logic [C2_W-1:0] i_coeff_two,
	input wire logic [C3_W-1:0] i_coeff_three,
	input wire logic [C4_W-1:0] i_coeff_four,
	input wire logic [C5_W-1:0] i_coeff_five,
	input wire logic [C6_W-1:0] i_coeff_six,
	// Converter
	output logic o_conv_start,
	output logic o_conv_temp,
	input wire logic [WORD_W-1:0] i_adc_data,
	input wire logic i_adc_valid,
	output logic o_adc_ready
);

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ACK = 4'h2,
		ST_CONV = 4'h4,
		ST_READ = 4'h8
	} bsr_state_e;

	localparam int CW = $clog2(DEPTH + 1);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic sclk_s1, sclk_s2, sclk_s3;
	logic din_s1, din_s2;
	logic sclk_rise;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			din_s1 <= 1'b0;
			din_s2 <= 1'b0;
		end else begin
			sclk_s1 <= i_sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			din_s1 <= i_din;
			din_s2 <= din_s1;
		end
	end

	// Data moves on the host's falling edge, so it is settled here
	assign sclk_rise = sclk_s2 & ~sclk_s3;

	// ----------------------------------------------------------------
	// Result buffer
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] fifo_mem [DEPTH];
	logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [CW-1:0] fifo_cnt, next_fifo_cnt;
	logic next_adc_ready;
	logic push, pop;
	logic [WORD_W-1:0] fifo_head;

	assign push = i_adc_valid & o_adc_ready;
	assign fifo_head = fifo_mem[rd_ptr];

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_fifo_cnt = fifo_cnt;
		if (push) begin
			next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_fifo_cnt = fifo_cnt + 1'b1;
		end else if (pop && !push) begin
			next_fifo_cnt = fifo_cnt - 1'b1;
		end
		// Converter stalls once all DEPTH slots hold unread words
		next_adc_ready = (next_fifo_cnt < CW'(DEPTH));
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fifo_cnt <= '0;
			o_adc_ready <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fifo_cnt <= next_fifo_cnt;
			o_adc_ready <= next_adc_ready;
		end
	end

	always_ff @(posedge i_clock) begin
		if (push) begin
			fifo_mem[wr_ptr] <= i_adc_data;
		end
	end

	// ----------------------------------------------------------------
	// Protocol engine
	// ----------------------------------------------------------------
	bsr_state_e state, next_state;
	logic [RST_LEN-1:0] hist, next_hist;
	logic [4:0] cnt, next_cnt;
	logic [31:0] wd, next_wd;
	logic [WORD_W-1:0] shift, next_shift;
	logic is_conv, next_is_conv;
	logic next_dout, next_conv_start, next_conv_temp;
	logic frame_ok;
	logic [3:0] code;
	logic [WORD_W-1:0] clamped;
	logic [WORD_W-1:0] cal_word;

	always_comb begin
		next_hist = hist;
		if (sclk_rise) begin
			next_hist = {hist[RST_LEN-2:0], din_s2};
		end
		code = next_hist[5:2];
		// Stop pattern is matched on its second bit, so the
		// acknowledge can rise during the last one
		frame_ok = (next_hist[8:6] == START_PAT) &&
			(next_hist[1:0] == STOP_PAT[1:0]);
		if (fifo_head < ADC_MIN) begin
			clamped = ADC_MIN;
		end else if (fifo_head > ADC_MAX) begin
			clamped = ADC_MAX;
		end else begin
			clamped = fifo_head;
		end
		case (code)
			CMD_CALIB_WORD_ONE: cal_word = {i_coeff_one, i_coeff_five[10]};
			CMD_CALIB_WORD_TWO: cal_word = {i_coeff_five[9:0], i_coeff_six};
			CMD_CALIB_WORD_THREE: cal_word = {i_coeff_four, i_coeff_two[11:6]};
			default: cal_word = {i_coeff_three, i_coeff_two[5:0]};
		endcase
	end

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_wd = wd;
		next_shift = shift;
		next_is_conv = is_conv;
		next_dout = o_dout;
		next_conv_start = 1'b0;
		next_conv_temp = o_conv_temp;
		pop = 1'b0;
		case (state)
			ST_IDLE: begin
				if (sclk_rise && frame_ok) begin
					case (code)
						CMD_PRESSURE, CMD_TEMP: begin
							next_state = ST_ACK;
							next_is_conv = 1'b1;
							next_conv_temp = (code == CMD_TEMP);
							next_dout = 1'b1;
							next_cnt = '0;
						end
						CMD_CALIB_WORD_ONE, CMD_CALIB_WORD_TWO, CMD_CALIB_WORD_THREE, CMD_CALIB_WORD_FOUR: begin
							next_state = ST_ACK;
							next_is_conv = 1'b0;
							next_shift = cal_word;
							next_cnt = '0;
						end
						default: next_state = ST_IDLE;
					endcase
				end
			end
			ST_ACK: begin
				if (sclk_rise) begin
					next_cnt = cnt + 1'b1;
					if (!is_conv) begin
						next_state = ST_READ;
						next_cnt = '0;
					end else if (cnt == ACK_CLOCKS - 1'b1) begin
						// Last stop bit plus the two trailing clocks
						next_state = ST_CONV;
						next_conv_start = 1'b1;
						next_wd = '0;
					end
				end
			end
			ST_CONV: begin
				next_wd = wd + 1'b1;
				if (fifo_cnt != '0) begin
					pop = 1'b1;
					next_shift = clamped;
					next_dout = 1'b0;
					next_state = ST_READ;
					next_cnt = '0;
				end else if (wd >= 32'(CONV_CYCLES - 1)) begin
					// A silent converter must not hang the link
					next_shift = ADC_MIN;
					next_dout = 1'b0;
					next_state = ST_READ;
					next_cnt = '0;
				end
			end
			ST_READ: begin
				// Nothing moves without an edge, so pauses are free
				if (sclk_rise) begin
					if (cnt < RESULT_BITS) begin
						next_dout = shift[WORD_W-1];
						next_shift = {shift[WORD_W-2:0], 1'b0};
						next_cnt = cnt + 1'b1;
					end else begin
						next_dout = 1'b0;
						next_state = ST_IDLE;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (sclk_rise && next_hist == RST_PAT) begin
			next_state = ST_IDLE;
			next_dout = 1'b0;
			next_cnt = '0;
			next_conv_start = 1'b0;
			pop = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state <= ST_IDLE;
			hist <= '0;
			cnt <= '0;
			wd <= '0;
			shift <= '0;
			is_conv <= 1'b0;
			o_dout <= 1'b0;
			o_conv_start <= 1'b0;
			o_conv_temp <= 1'b0;
		end else begin
			state <= next_state;
			hist <= next_hist;
			cnt <= next_cnt;
			wd <= next_wd;
			shift <= next_shift;
			is_conv <= next_is_conv;
			o_dout <= next_dout;
			o_conv_start <= next_conv_start;
			o_conv_temp <= next_conv_temp;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);

	sample_on_rise_a: assert property (
		!sclk_rise |=> $stable(hist))
		else $error("history moved without a clock rise");
	ack_level_a: assert property (
		(state == ST_ACK && is_conv) |-> o_dout)
		else $error("acknowledge not high");
	conv_busy_a: assert property (
		state == ST_CONV |-> o_dout)
		else $error("output low during conversion");
	conv_end_a: assert property (
		(state == ST_CONV && next_state == ST_READ) |=> !o_dout)
		else $error("no falling edge at conversion end");
	conv_bound_a: assert property (
		state == ST_CONV |-> wd < 32'(CONV_CYCLES))
		else $error("conversion overran its time");
	pause_hold_a: assert property (
		(state == ST_READ && !sclk_rise) |=> $stable(o_dout))
		else $error("output moved while clock idle");
	read_count_a: assert property (
		state == ST_READ |-> cnt <= RESULT_BITS)
		else $error("readout bit count overran");
	reset_seq_a: assert property (
		(sclk_rise && next_hist == RST_PAT) |=> state == ST_IDLE && !o_dout)
		else $error("reset pattern not honoured");
	clamp_range_a: assert property (
		pop |=> shift >= ADC_MIN && shift <= ADC_MAX)
		else $error("result outside converter range");
	start_pulse_a: assert property (
		o_conv_start |-> $past(state) == ST_ACK && !$past(o_conv_start))
		else $error("conversion start not a single pulse");

endmodule
